//--- core/tcw_decoder.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "tcw_defs.svh"
module tcw_decoder (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// terminal pins
	input  wire logic              touch_press,
	input  wire logic              touch_buzz_stop,
	input  wire logic              print_done,
	input  wire logic              menu_or_error,
	// outputs
	output logic                   screen_on,
	output tcw_pkg::tcw_light_s    backlight,
	output logic                   buzzer,
	output logic                   history_clear,
	output logic                   print_start,
	output logic                   window_block,
	output logic                   input_block
);
	logic [15:0] ctrl_reg;
	logic [15:0] prev_reg;
	logic [15:0] stat_reg;
	logic [2:0]  local_reg;
	logic        started_reg;
	logic [3:0]  pin_q;
	logic        tp_q, stop_q, done_q, menu_q;
	logic [27:0] tick_cnt_reg;
	logic        tick;
	logic [10:0] ms_cnt_reg;
	logic        blank_reg;
	logic        buzz_mute_reg;
	logic        hist_pend_reg;
	tcw_pkg::tcw_print_e pr_reg;
	tcw_pkg::tcw_buzz_e  buzz_sel;
	logic        wr, rd, is_ctrl, changed;

	tcw_sync #(.W(4)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({touch_press, touch_buzz_stop, print_done, menu_or_error}),
		.q       (pin_q)
	);
	assign {tp_q, stop_q, done_q, menu_q} = pin_q;

	function automatic logic bit_rise(input logic [15:0] n,
		input logic [15:0] o, input int b);
		bit_rise = n[b] & ~o[b];
	endfunction : bit_rise

	function automatic logic masked_diff(input logic [15:0] n,
		input logic [15:0] o, input logic [15:0] m);
		masked_diff = ((n ^ o) & m) != 16'h0000;
	endfunction : masked_diff

	assign pready  = 1'b1;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & ~penable & ~pwrite;
	assign is_ctrl = (paddr == `TCW_CTRL_OFS);
	assign pslverr = psel & penable & ~(is_ctrl |
		(paddr == `TCW_STAT_OFS) | (paddr == `TCW_LOCAL_OFS));
	// only assigned bits count as a change
	assign changed = started_reg &
		masked_diff(ctrl_reg, prev_reg, `TCW_CTRL_MASK);

	// 1 ms tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 28'h0000000;
		end else if (tick) begin
			tick_cnt_reg <= 28'h0000000;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 28'h0000001;
		end
	end
	assign tick = (tick_cnt_reg == 28'(`TCW_TICK_CYC - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_reg <= 11'h000;
		end else if (tick) begin
			ms_cnt_reg <= (ms_cnt_reg == 11'(2 * `TCW_LONG_MS - 1)) ?
				11'h000 : ms_cnt_reg + 11'h001;
		end
	end

	// control word, software write plus hardware self-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= 16'h0000;
		end else begin
			if (wr && is_ctrl && stat_reg[`TCW_S_RUN]) begin
				ctrl_reg <= pwdata[15:0];
			end
			if (hist_pend_reg && !(wr && is_ctrl)) begin
				ctrl_reg[`TCW_B_HIST] <= 1'b0;
			end
			if (pr_reg == tcw_pkg::TCW_PR_RUN && stat_reg[`TCW_S_PBUSY]
				&& !(wr && is_ctrl)) begin
				ctrl_reg[`TCW_B_PRINT] <= 1'b0;
			end
		end
	end

	// first word after start-up is only a baseline
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg    <= 16'h0000;
			started_reg <= 1'b0;
		end else begin
			prev_reg    <= ctrl_reg;
			started_reg <= 1'b1;
		end
	end

	// blanking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_reg <= 1'b0;
		end else if (changed && !ctrl_reg[`TCW_B_DISP]
			&& prev_reg[`TCW_B_DISP]) begin
			blank_reg <= 1'b1;
		end else if (changed && bit_rise(ctrl_reg, prev_reg, `TCW_B_DISP)) begin
			blank_reg <= 1'b0;
		end else if (tp_q) begin
			blank_reg <= 1'b0;
		end
	end
	assign screen_on = ~blank_reg;

	// backlight; local_reg[1] selects colour variant
	always_comb begin
		logic flash_on;
		flash_on  = (ms_cnt_reg % 11'(2 * `TCW_FLASH_MS)) <
			11'(`TCW_FLASH_MS);
		backlight = '0;
		if (!blank_reg && ctrl_reg[`TCW_B_DISP]) begin
			backlight.on = ctrl_reg[`TCW_B_MODE] | flash_on;
			if (local_reg[1] && ctrl_reg[`TCW_B_COLOR]) begin
				backlight.red = 1'b1;
			end else begin
				backlight.white = 1'b1;
			end
		end
	end

	// buzzer priority
	always_comb begin
		if (ctrl_reg[`TCW_B_CONT]) begin
			buzz_sel = tcw_pkg::TCW_BZ_CONT;
		end else if (ctrl_reg[`TCW_B_SHORT]) begin
			buzz_sel = tcw_pkg::TCW_BZ_SHORT;
		end else if (ctrl_reg[`TCW_B_LONG]) begin
			buzz_sel = tcw_pkg::TCW_BZ_LONG;
		end else begin
			buzz_sel = tcw_pkg::TCW_BZ_OFF;
		end
	end

	// stop switch mutes until the buzzer bits change again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buzz_mute_reg <= 1'b0;
		end else if (stop_q) begin
			buzz_mute_reg <= 1'b1;
		end else if (changed
			&& masked_diff(ctrl_reg, prev_reg, `TCW_BUZZ_MASK)) begin
			buzz_mute_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buzzer <= 1'b0;
		end else if (buzz_mute_reg || !local_reg[0]) begin
			buzzer <= 1'b0;
		end else begin
			case (buzz_sel)
				tcw_pkg::TCW_BZ_CONT:  buzzer <= 1'b1;
				tcw_pkg::TCW_BZ_SHORT: buzzer <= (ms_cnt_reg %
					11'(2 * `TCW_SHORT_MS)) < 11'(`TCW_SHORT_MS);
				tcw_pkg::TCW_BZ_LONG:  buzzer <= ms_cnt_reg <
					11'(`TCW_LONG_MS);
				default:               buzzer <= 1'b0;
			endcase
		end
	end

	// history reset pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			history_clear <= 1'b0;
			hist_pend_reg <= 1'b0;
		end else begin
			history_clear <= changed && bit_rise(ctrl_reg, prev_reg,
				`TCW_B_HIST);
			hist_pend_reg <= changed && bit_rise(ctrl_reg, prev_reg,
				`TCW_B_HIST);
		end
	end

	// print sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pr_reg      <= tcw_pkg::TCW_PR_IDLE;
			print_start <= 1'b0;
		end else begin
			print_start <= 1'b0;
			case (pr_reg)
				tcw_pkg::TCW_PR_IDLE: begin
					if (changed && bit_rise(ctrl_reg, prev_reg, `TCW_B_PRINT))
					begin
						pr_reg      <= tcw_pkg::TCW_PR_START;
						print_start <= 1'b1;
					end
				end
				tcw_pkg::TCW_PR_START: begin
					pr_reg <= tcw_pkg::TCW_PR_RUN;
				end
				tcw_pkg::TCW_PR_RUN: begin
					if (done_q) begin
						pr_reg <= tcw_pkg::TCW_PR_IDLE;
					end
				end
				default: pr_reg <= tcw_pkg::TCW_PR_IDLE;
			endcase
		end
	end

	// status word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= 16'h0000;
		end else begin
			stat_reg[`TCW_S_RUN]   <= local_reg[2] & ~menu_q;
			stat_reg[`TCW_S_PBUSY] <= ~menu_q && !(pr_reg ==
				tcw_pkg::TCW_PR_IDLE) && !(pr_reg == tcw_pkg::TCW_PR_RUN
				&& done_q);
		end
	end

	// local settings: [0] buzzer enable, [1] colour variant, [2] run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			local_reg <= 3'h5;
		end else if (wr && paddr == `TCW_LOCAL_OFS) begin
			local_reg <= pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window_block <= 1'b0;
			input_block  <= 1'b0;
		end else begin
			window_block <= ctrl_reg[`TCW_B_WIN];
			input_block  <= ctrl_reg[`TCW_B_INP];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd) begin
			case (paddr)
				`TCW_CTRL_OFS:  prdata <= {16'h0000, ctrl_reg};
				`TCW_STAT_OFS:  prdata <= {16'h0000, stat_reg};
				`TCW_LOCAL_OFS: prdata <= {29'h00000000, local_reg};
				default:        prdata <= 32'h00000000;
			endcase
		end
	end
endmodule : tcw_decoder

//--- core/tcw_defs.svh
// What this block does
// - display bit written 0 turns backlight off at once and blanks screen one clock later
// - display bit on restores screen and backlight; touch press restores screen only
// - buzzer requests: continuous bit 13, short bit 12, long bit 9
// - short pattern 0.5 s on/off, long 1.0 s on/off, continuous steady
// - several buzzer requests: continuous, then short, then long wins
// - buzzer-stop touch switch silences a sounding buzzer
// - buzzer output also gated by local buzzer enable setting
// - local state changes never write back into the control word
// - history-reset bit rising clears history, then bit returns to 0
// - colour variant: bit 10 colour, bit 8 steady versus flashing
// - plain variant ignores bit 10, bit 8 steady or flashing white
// - display bit 0 keeps backlight off, colour and mode ignored
// - print bit rising starts print; a running print cannot abort
// - print bit cleared once printing began and busy flag is set
// - window-disable bit 1 blocks window opening and closes windows
// - input-disable bit 1 rejects numeric, text and thumbwheel entry
// - nothing acts at power-up; only later changes of the word act
// - printer-busy set while printing, cleared at end, menu or error
// - status bit 15 set only in run mode; control-word writes ignored otherwise
`ifndef TCW_DEFS_SVH
`define TCW_DEFS_SVH
`define TCW_CTRL_OFS     12'h000
`define TCW_STAT_OFS     12'h004
`define TCW_LOCAL_OFS    12'h008
`define TCW_EVT_OFS      12'h00C
`define TCW_B_DISP       15
`define TCW_B_CONT       13
`define TCW_B_SHORT      12
`define TCW_B_HIST       11
`define TCW_B_COLOR      10
`define TCW_B_LONG       9
`define TCW_B_MODE       8
`define TCW_B_PRINT      7
`define TCW_B_WIN        6
`define TCW_B_INP        5
`define TCW_S_RUN        15
`define TCW_S_PBUSY      7
`define TCW_CTRL_MASK    16'hBFE0
`define TCW_BUZZ_MASK    16'h3200
`define TCW_CLK_HZ       250000000
`define TCW_TICK_MS      1
`define TCW_TICK_CYC     (`TCW_CLK_HZ / 1000 * `TCW_TICK_MS)
`define TCW_SHORT_MS     500
`define TCW_LONG_MS      1000
`define TCW_FLASH_MS     500
`endif

//--- core/tcw_pkg.sv
package tcw_pkg;
	typedef enum logic [1:0] {TCW_BZ_OFF, TCW_BZ_CONT, TCW_BZ_SHORT,
		TCW_BZ_LONG} tcw_buzz_e;
	typedef enum logic [1:0] {TCW_PR_IDLE, TCW_PR_START, TCW_PR_RUN}
		tcw_print_e;
	typedef struct packed {
		logic on;
		logic red;
		logic white;
	} tcw_light_s;
endpackage : tcw_pkg

//--- core/tcw_sync.sv
`timescale 1ns/1ps
module tcw_sync #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// async in, filtered out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q      <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					q[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule : tcw_sync

//--- sim/tcw_decoder_checker.sv
`timescale 1ns/1ps
module tcw_decoder_checker (
	// clock and reset
	input wire logic          pclk,
	input wire logic          presetn,
	// apb
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	// terminal pins
	input wire logic          touch_press,
	input wire logic          touch_buzz_stop,
	input wire logic          print_done,
	input wire logic          menu_or_error,
	// outputs
	input wire logic          screen_on,
	input tcw_pkg::tcw_light_s backlight,
	input wire logic          buzzer,
	input wire logic          history_clear,
	input wire logic          print_start,
	input wire logic          window_block,
	input wire logic          input_block
);
	logic d15;
	wire  cw = psel && penable && pwrite && paddr == 12'h000;
	// last written display bit
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) d15 <= 1'b0;
		else if (cw) d15 <= pwdata[15];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_blank; cw && !pwdata[15] && d15 |-> ##[1:4] !screen_on;
	endproperty
	a_blank: assert property (p_blank)
		else $error("screen not blanked");
	property p_dark; !screen_on ##1 !screen_on |-> !backlight.on; endproperty
	a_dark: assert property (p_dark)
		else $error("backlight on while blank");
	property p_color; backlight.on |-> backlight.red != backlight.white;
	endproperty
	a_color: assert property (p_color)
		else $error("backlight colour invalid");
	property p_hist; history_clear |=> !history_clear; endproperty
	a_hist: assert property (p_hist)
		else $error("history pulse too long");
	property p_print; print_start |=> !print_start; endproperty
	a_print: assert property (p_print)
		else $error("print pulse too long");
	property p_stop; touch_buzz_stop [*8] |-> !buzzer; endproperty
	a_stop: assert property (p_stop)
		else $error("buzzer not silenced");
	property p_wake; touch_press [*8] |-> screen_on; endproperty
	a_wake: assert property (p_wake)
		else $error("screen not restored");
	property p_win; cw && pwdata[6] |-> ##[1:4] window_block; endproperty
	a_win: assert property (p_win)
		else $error("window block missing");
	property p_inp; cw && pwdata[5] |-> ##[1:4] input_block; endproperty
	a_inp: assert property (p_inp)
		else $error("input block missing");
	c_hist: cover property (history_clear);
	c_print: cover property (print_start);
	c_buzz: cover property (buzzer);
endmodule : tcw_decoder_checker

//--- sim/tcw_ctl_model.sv
`timescale 1ns/1ps
module tcw_ctl_model (
	// clock
	input wire logic        pclk,
	// apb master
	output logic            psel,
	output logic            penable,
	output logic            pwrite,
	output logic [11:0]     paddr,
	output logic [31:0]     pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// print only when the printer is idle
	task automatic print_req(input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		xfer(1'b0, 12'h004, 32'h0, r, e);
		if (r[7] === 1'b0) xfer(1'b1, 12'h000, d, r, e);
	endtask : print_req
endmodule : tcw_ctl_model

//--- sim/tcw_decoder_test.sv
`timescale 1ns/1ps
module tcw_decoder_test;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel, penable, pwrite, pready, pslverr;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata, r;
	logic                e;
	logic                touch_press = 1'b0;
	logic                touch_buzz_stop = 1'b0;
	logic                print_done = 1'b0;
	logic                menu_or_error = 1'b0;
	logic                screen_on, buzzer, history_clear, print_start;
	logic                window_block, input_block;
	tcw_pkg::tcw_light_s backlight;
	int                  fails = 0;
	int                  total_checks = 0;
	always #2 pclk = ~pclk;
	tcw_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.touch_press(touch_press), .touch_buzz_stop(touch_buzz_stop),
		.print_done(print_done), .menu_or_error(menu_or_error),
		.screen_on(screen_on), .backlight(backlight), .buzzer(buzzer),
		.history_clear(history_clear), .print_start(print_start),
		.window_block(window_block), .input_block(input_block));
	tcw_ctl_model mdl (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task w(input logic [11:0] a, input logic [31:0] d);
		mdl.xfer(1'b1, a, d, r, e);
	endtask : w
	task rdm(input logic [11:0] a, input logic [31:0] m, exp);
		mdl.xfer(1'b0, a, 32'h0, r, e);
		chk(r & m, exp);
	endtask : rdm
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	// sel 0 watches history_clear, 1 watches print_start
	task wt(input logic sel);
		repeat (20) begin
			if ((sel ? print_start : history_clear) !== 1'b1) begin
				@(negedge pclk);
			end
		end
		chk(sel ? print_start : history_clear, 1'b1);
	endtask : wt
	task t_light;
		w(12'h008, 32'h7);
		w(12'h000, 32'h8500);
		cyc(4);
		chk(backlight, 3'b110);
		w(12'h000, 32'h8100);
		cyc(4);
		chk(backlight, 3'b101);
		w(12'h008, 32'h5);
		w(12'h000, 32'h8500);
		cyc(4);
		chk(backlight, 3'b101);
		w(12'h000, 32'h0500);
		cyc(4);
		chk({screen_on, backlight}, 4'h0);
		w(12'h000, 32'h8500);
		cyc(4);
		chk({screen_on, backlight}, 4'hD);
		w(12'h000, 32'h0500);
		cyc(4);
		touch_press <= 1'b1;
		cyc(8);
		touch_press <= 1'b0;
		chk(screen_on, 1'b1);
	endtask : t_light
	task t_hist;
		w(12'h000, 32'h0800);
		wt(1'b0);
		cyc(2);
		rdm(12'h000, 32'hFFFF, 32'h0);
	endtask : t_hist
	task t_print;
		mdl.print_req(32'h0080);
		wt(1'b1);
		cyc(4);
		rdm(12'h004, 32'h80, 32'h80);
		rdm(12'h000, 32'h80, 32'h0);
		print_done <= 1'b1;
		cyc(8);
		print_done <= 1'b0;
		cyc(2);
		rdm(12'h004, 32'h80, 32'h0);
	endtask : t_print
	task t_block;
		w(12'h000, 32'h0060);
		cyc(4);
		chk({window_block, input_block}, 2'b11);
		w(12'h000, 32'h401F);
		cyc(4);
		chk({window_block, input_block, buzzer}, 3'b000);
	endtask : t_block
	task t_buzz;
		w(12'h000, 32'h2000);
		cyc(4);
		chk(buzzer, 1'b1);
		touch_buzz_stop <= 1'b1;
		cyc(8);
		touch_buzz_stop <= 1'b0;
		chk(buzzer, 1'b0);
		cyc(8);
		w(12'h000, 32'h2000);
		cyc(4);
		chk(buzzer, 1'b0);
		w(12'h000, 32'h3200);
		cyc(100);
		chk(buzzer, 1'b1);
		w(12'h008, 32'h4);
		cyc(4);
		chk(buzzer, 1'b0);
		rdm(12'h000, 32'hFFFF, 32'h3200);
		w(12'h008, 32'h5);
	endtask : t_buzz
	task print_verdict;
		if (fails == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		cyc(6);
		presetn <= 1'b1;
		cyc(2);
		chk({screen_on, backlight, buzzer}, 5'b10000);
		rdm(12'h008, 32'h7, 32'h5);
		rdm(12'h004, 32'h8080, 32'h8000);
		t_light;
		t_hist;
		t_print;
		t_block;
		t_buzz;
		mdl.xfer(1'b0, 12'h010, 32'h0, r, e);
		chk(e, 1'b1);
		chk(r, 32'h0);
		print_verdict;
	end
	initial begin
		#200000;
		fails++;
		print_verdict;
	end
endmodule : tcw_decoder_test
bind tcw_decoder tcw_decoder_checker chk_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.touch_press(touch_press), .touch_buzz_stop(touch_buzz_stop),
	.print_done(print_done), .menu_or_error(menu_or_error),
	.screen_on(screen_on), .backlight(backlight), .buzzer(buzzer),
	.history_clear(history_clear), .print_start(print_start),
	.window_block(window_block), .input_block(input_block));
